/* lmif_pkg.sv */
// constants and carrier types for the link module interrupt and fault block
package lmif_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // dual-port register map (word indices)
  localparam int unsigned DP_AW               = 12;
  localparam logic [11:0] REG_INT_STATUS_CTRL = 12'h000;
  localparam logic [11:0] REG_FATAL_DETAIL    = 12'h03c;

  // interrupt_status_control fields, bit 15 is the most significant
  localparam int unsigned ISC_PEND_BIT  = 15;
  localparam int unsigned ISC_EN_BIT    = 7;
  localparam int unsigned ISC_ALLOC_BIT = 2;
  localparam int unsigned ISC_SEL_LSB   = 0;
  localparam int unsigned ISC_SEL_W     = 2;
  localparam int unsigned IRQ_LINES     = 4;

  ////////////////////////////////////////////////////////////////////////////
  // fatal detail codes
  localparam logic [15:0] ERR_TMR0_SPURIOUS = 16'h01f0;
  localparam logic [15:0] ERR_CHA_BASE      = 16'h02f0;
  localparam logic [15:0] ERR_CHB_STATUS    = 16'h03f0;
  localparam logic [15:0] DETAIL_RESET      = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // display glyphs: 0..15 hex digits, plus letter r and blank
  localparam logic [4:0] GLYPH_3     = 5'h03;
  localparam logic [4:0] GLYPH_4     = 5'h04;
  localparam logic [4:0] GLYPH_C     = 5'h0c;
  localparam logic [4:0] GLYPH_D     = 5'h0d;
  localparam logic [4:0] GLYPH_E     = 5'h0e;
  localparam logic [4:0] GLYPH_R     = 5'h10;
  localparam logic [4:0] GLYPH_BLANK = 5'h1f;

  // power-up diagnostics: processor, program memory, ram, timer, dma,
  // dual-port memory, memory management, parallel port, watchdog
  localparam int unsigned DIAG_N = 9;
  localparam logic [4:0] DIAG_GLYPH [DIAG_N] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05,
                                                 5'h06, 5'h07, 5'h09, 5'h0b};

  ////////////////////////////////////////////////////////////////////////////
  // fixed serial character format
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned BAUD_HZ     = 41_600;
  localparam int unsigned BAUD_DIV    = CLK_HZ / BAUD_HZ;
  localparam int unsigned DATA_BITS   = 8;
  localparam int unsigned STOP_BITS   = 1;
  localparam logic        PARITY_ODD  = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic             wr;
    logic             rd;
    logic [11:0]      addr;
    logic [15:0]      wdata;
  } lmif_dp_req_t;

  typedef struct packed {
    logic             tmr0_irq;
    logic [3:0]       cha_irq;
    logic             chb_stat_irq;
  } lmif_fault_t;

  typedef struct packed {
    logic             dp;
    logic [4:0]       glyph;
  } lmif_disp_t;

  typedef struct packed {
    logic             pend;
    logic             en;
    logic             alloc;
    logic [1:0]       sel;
    logic [15:0]      detail;
    logic             fatal;
    lmif_disp_t       fatal_disp;
    logic             diag_valid;
    logic [4:0]       diag_glyph;
    logic [10:0]      baud_cnt;
    logic             baud_tick;
    logic             pf_meta;
    logic             pf_sync;
    logic             wd_meta;
    logic             wd_sync;
    logic [15:0]      rdata;
    lmif_disp_t       disp;
  } lmif_state_t;

endpackage

/* lmif_core.sv */
// interrupt status/control word, fatal error latch and fault display
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// RULE_01 - pending bit 15 sets on a raised interrupt, clears on host acknowledge
// RULE_02 - enable bit gates backplane interrupts; disabled means no line asserted
// RULE_03 - allocation bit 2 reads 1 when a host has claimed the word
// RULE_04 - line-select bits 1:0 pick which of four backplane lines is driven
// RULE_05 - only register 0 is the status/control word; others are ignored for it
// RULE_06 - bit 15 is the most significant bit throughout the map
// RULE_07 - host operating system writes enable, allocation and line-select fields
// RULE_08 - serial format fixed: 41.6k baud, 8 data, 1 stop, odd parity
// RULE_09 - fatal error latches a 16-bit detail code into register 60
// RULE_10 - timer channel 0 interrupt is fatal: display .3, detail 01f0
// RULE_11 - any channel A interrupt is fatal: display .4, detail 02f0 to 02f3
// RULE_12 - channel B status change interrupt is fatal: display .4, detail 03f0
// RULE_13 - failed power-up diagnostics show codes 0 to 3, 5 to 7, 9 and b
// RULE_14 - code C shows only while no messages arrive from the drive
// RULE_15 - backplane watchdog failure shows d and halts serial traffic
// RULE_16 - code E shows from power failure detection onward; here E shows only while the synchronised power-fail pin stays high
// RULE_17 - code .r shows on incompatible software revisions
// RULE_18 - latched detail and displayed fatal code hold until reset
module lmif_core
  import lmif_pkg::*;
#(
  parameter int unsigned BAUD_DIVISOR = BAUD_DIV
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  // dual-port register access
  input  wire lmif_dp_req_t         dp_req,
  output logic [15:0]               dp_rdata,
  // interrupt events and backplane lines
  input  wire logic                 irq_event,
  input  wire logic                 irq_ack,
  output logic [IRQ_LINES-1:0]      irq_line,
  // run-time interrupt causes and diagnostics
  input  wire lmif_fault_t          fault_irq,
  input  wire logic [DIAG_N-1:0]    diag_fail,
  input  wire logic                 link_rx_idle,
  input  wire logic                 rev_mismatch,
  // asynchronous pins
  input  wire logic                 power_fail_pin,
  input  wire logic                 bp_wdog_fail_pin,
  // display and serial control
  output lmif_disp_t                disp,
  output logic                      serial_enable,
  output logic                      baud_tick
);

  lmif_state_t st_reg;
  lmif_state_t st_next;
  logic        wr_isc;
  logic        fatal_evt;
  lmif_disp_t  fatal_disp_evt;
  logic [15:0] fatal_code_evt;

  ////////////////////////////////////////////////////////////////////////////
  // fatal cause decode, fixed priority: timer, channel A, channel B
  always_comb begin
    fatal_evt      = 1'b0;
    fatal_disp_evt = '{dp: 1'b1, glyph: GLYPH_4};
    fatal_code_evt = DETAIL_RESET;
    if (fault_irq.tmr0_irq) begin
      fatal_evt      = 1'b1;
      fatal_disp_evt = '{dp: 1'b1, glyph: GLYPH_3};  // see RULE_10
      fatal_code_evt = ERR_TMR0_SPURIOUS;            // see RULE_10
    end else if (|fault_irq.cha_irq) begin
      fatal_evt = 1'b1;
      for (int i = 3; i >= 0; i--) begin
        if (fault_irq.cha_irq[i]) begin
          fatal_code_evt = ERR_CHA_BASE + 16'(i);    // see RULE_11
        end
      end
    end else if (fault_irq.chb_stat_irq) begin
      // break and carrier loss only reach here via the masked interrupt
      fatal_evt      = 1'b1;
      fatal_code_evt = ERR_CHB_STATUS;               // see RULE_12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  assign wr_isc = dp_req.wr && (dp_req.addr == REG_INT_STATUS_CTRL);  // see RULE_05

  always_comb begin
    st_next = st_reg;

    // pin synchronisers
    st_next.pf_meta = power_fail_pin;
    st_next.pf_sync = st_reg.pf_meta;
    st_next.wd_meta = bp_wdog_fail_pin;
    st_next.wd_sync = st_reg.wd_meta;

    // pending flag: a new event wins over a same-cycle acknowledge
    if (irq_event) begin
      st_next.pend = 1'b1;                           // see RULE_01
    end else if (irq_ack) begin
      st_next.pend = 1'b0;                           // see RULE_01
    end

    // host-owned fields; pending bit is not writable
    if (wr_isc) begin
      st_next.en    = dp_req.wdata[ISC_EN_BIT];      // see RULE_02
      st_next.alloc = dp_req.wdata[ISC_ALLOC_BIT];   // see RULE_03
      st_next.sel   = dp_req.wdata[ISC_SEL_LSB +: ISC_SEL_W];  // see RULE_04
    end

    // first fatal error wins and holds until reset
    if (fatal_evt && !st_reg.fatal) begin
      st_next.fatal      = 1'b1;                     // see RULE_18
      st_next.detail     = fatal_code_evt;           // see RULE_09
      st_next.fatal_disp = fatal_disp_evt;
    end

    // lowest-numbered failing diagnostic is latched
    if (!st_reg.diag_valid && |diag_fail) begin
      st_next.diag_valid = 1'b1;
      for (int i = DIAG_N - 1; i >= 0; i--) begin
        if (diag_fail[i]) begin
          st_next.diag_glyph = DIAG_GLYPH[i];        // see RULE_13
        end
      end
    end

    // baud enable; frozen while the backplane watchdog is failed
    st_next.baud_tick = 1'b0;
    if (st_reg.wd_sync) begin
      st_next.baud_cnt = '0;                         // see RULE_15
    end else if (st_reg.baud_cnt == 11'(BAUD_DIVISOR - 1)) begin
      st_next.baud_cnt  = '0;                        // see RULE_08
      st_next.baud_tick = 1'b1;
    end else begin
      st_next.baud_cnt = st_reg.baud_cnt + 11'h001;
    end

    // register read, word layout msb is bit 15
    st_next.rdata = 16'h0000;
    if (dp_req.rd) begin
      if (dp_req.addr == REG_INT_STATUS_CTRL) begin
        st_next.rdata[ISC_PEND_BIT]                = st_reg.pend;  // see RULE_06
        st_next.rdata[ISC_EN_BIT]                  = st_reg.en;
        st_next.rdata[ISC_ALLOC_BIT]               = st_reg.alloc; // see RULE_03
        st_next.rdata[ISC_SEL_LSB +: ISC_SEL_W]    = st_reg.sel;
      end else if (dp_req.addr == REG_FATAL_DETAIL) begin
        st_next.rdata = st_reg.detail;               // see RULE_09
      end
    end

    // display priority: fatal, power, watchdog, diagnostic, revision, link
    if (st_reg.fatal) begin
      st_next.disp = st_reg.fatal_disp;              // see RULE_18
    end else if (st_reg.pf_sync) begin
      st_next.disp = '{dp: 1'b0, glyph: GLYPH_E};    // see RULE_16
    end else if (st_reg.wd_sync) begin
      st_next.disp = '{dp: 1'b0, glyph: GLYPH_D};    // see RULE_15
    end else if (st_reg.diag_valid) begin
      st_next.disp = '{dp: 1'b0, glyph: st_reg.diag_glyph};  // see RULE_13
    end else if (rev_mismatch) begin
      st_next.disp = '{dp: 1'b1, glyph: GLYPH_R};    // see RULE_17
    end else if (link_rx_idle) begin
      st_next.disp = '{dp: 1'b0, glyph: GLYPH_C};    // see RULE_14
    end else begin
      st_next.disp = '{dp: 1'b0, glyph: GLYPH_BLANK};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st_reg            <= '0;
      st_reg.detail     <= DETAIL_RESET;
      st_reg.disp.glyph <= GLYPH_BLANK;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs; one line only, and none unless enabled
  always_comb begin
    irq_line = '0;
    if (st_reg.pend && st_reg.en) begin
      irq_line[st_reg.sel] = 1'b1;                   // see RULE_02 RULE_04
    end
  end

  // a fatal stop also silences the link, not just the watchdog
  assign serial_enable = !st_reg.wd_sync && !st_reg.fatal;  // see RULE_15
  assign baud_tick     = st_reg.baud_tick;
  assign dp_rdata      = st_reg.rdata;
  assign disp          = st_reg.disp;

endmodule

`default_nettype wire

/* lmif_core_checker.sv */
// concurrent checks on the interrupt and fault block ports
`timescale 1ns/1ns
`default_nettype none
module lmif_core_checker
  import lmif_pkg::*;
(
  // clock and reset
  input wire logic                 core_clk,
  input wire logic                 nrst,
  // watched ports
  input wire lmif_dp_req_t         dp_req,
  input wire logic [15:0]          dp_rdata,
  input wire logic                 irq_event,
  input wire logic                 irq_ack,
  input wire logic [IRQ_LINES-1:0] irq_line,
  input wire lmif_fault_t          fault_irq,
  input wire lmif_disp_t           disp,
  input wire logic                 baud_tick
);
  // shadow of host fields; only writes to word 0 count
  logic       en_reg;
  logic       al_reg;
  logic       fat_reg;
  logic [1:0] sel_reg;
  wire logic  cfg_wr = dp_req.wr && dp_req.addr == REG_INT_STATUS_CTRL;
  wire logic  any_f  = |fault_irq;
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      en_reg  <= 1'b0;
      al_reg  <= 1'b0;
      sel_reg <= 2'h0;
      fat_reg <= 1'b0;
    end else begin
      if (cfg_wr) begin
        en_reg  <= dp_req.wdata[ISC_EN_BIT];
        al_reg  <= dp_req.wdata[ISC_ALLOC_BIT];
        sel_reg <= dp_req.wdata[1:0];
      end
      if (any_f) fat_reg <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  line_select_a: assert property (
    irq_event && en_reg && !dp_req.wr |=> irq_line == (4'h1 << sel_reg))
    else $error("wrong interrupt line after event");
  ack_clear_a: assert property (
    irq_ack && !irq_event |=> irq_line == 4'h0) else $error("line held after ack");
  disabled_quiet_a: assert property (!en_reg |-> irq_line == 4'h0)
    else $error("line driven while disabled");
  unmapped_read_a: assert property (
    dp_req.rd && dp_req.addr != 12'h000 && dp_req.addr != 12'h03c |=> dp_rdata == 16'h0000)
    else $error("unmapped read not zero");
  cfg_readback_a: assert property (
    dp_req.rd && dp_req.addr == 12'h000 && !cfg_wr
    |=> dp_rdata[14:0] == {7'h00, en_reg, 4'h0, al_reg, sel_reg})
    else $error("status word fields wrong");
  fatal_code_a: assert property (
    any_f && !fat_reg
    |=> ##1 disp == {1'b1, ($past(fault_irq.tmr0_irq, 2) ? 5'h03 : 5'h04)})
    else $error("fatal display code wrong");
  fatal_hold_a: assert property (fat_reg && $past(fat_reg, 2) |-> $stable(disp))
    else $error("fatal display changed");
  baud_pulse_a: assert property (baud_tick |=> !baud_tick)
    else $error("baud tick wider than one cycle");
  cover property (irq_event && en_reg);
  cover property (any_f && !fat_reg);
  cover property (dp_req.rd && dp_req.addr == REG_FATAL_DETAIL && fat_reg);
endmodule
bind lmif_core lmif_core_checker chk (.core_clk, .nrst, .dp_req, .dp_rdata, .irq_event,
  .irq_ack, .irq_line, .fault_irq, .disp, .baud_tick);
`default_nettype wire

/* lmif_host_model.sv */
// backplane host model: word bus cycles and interrupt acknowledge
`timescale 1ns/1ns
`default_nettype none
module lmif_host_model
  import lmif_pkg::*;
(
  // clock
  input  wire logic         core_clk,
  // register bus
  output lmif_dp_req_t      dp_req,
  input  wire logic [15:0]  dp_rdata,
  // interrupt
  output logic              irq_ack
);
  initial begin
    dp_req = '0;
    irq_ack = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // released lines flip so a stale value never looks valid
  task automatic idle();
    dp_req = '{1'b0, 1'b0, ~dp_req.addr, ~dp_req.wdata};
  endtask
  // os-level config write, msb is bit 15
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(negedge core_clk);
    dp_req = '{1'b1, 1'b0, a, d};
    @(negedge core_clk);
    idle();
  endtask
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(negedge core_clk);
    dp_req = '{1'b0, 1'b1, a, 16'h0000};
    @(negedge core_clk);
    d = dp_rdata;
    idle();
  endtask
  // n sets the host delay, prompt or slow
  task automatic ack(input int n);
    repeat (n + 1) @(negedge core_clk);
    irq_ack = 1'b1;
    @(negedge core_clk);
    irq_ack = 1'b0;
  endtask
endmodule
`default_nettype wire

/* link_module_interrupt_fault_tb_top.sv */
// self-checking bench for the interrupt and fault block
`timescale 1ns/1ns
`default_nettype none
module link_module_interrupt_fault_tb_top
  import lmif_pkg::*;
;
  logic                 core_clk, nrst, irq_event, irq_ack, link_rx_idle, rev_mismatch;
  logic                 power_fail_pin, bp_wdog_fail_pin, serial_enable, baud_tick, en, al;
  logic [IRQ_LINES-1:0] irq_line;
  logic [DIAG_N-1:0]    diag_fail;
  logic [15:0]          dp_rdata, got;
  logic [1:0]           sel;
  logic [4:0]           dg [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06, 5'h07, 5'h09, 5'h0b};
  lmif_dp_req_t         dp_req;
  lmif_fault_t          fault_irq;
  lmif_disp_t           disp;
  int                   fail_count, checked, cyc, seed, k, ticks;
  // short baud divisor keeps the run brief
  lmif_core #(.BAUD_DIVISOR(4)) uut (.core_clk, .nrst, .dp_req, .dp_rdata, .irq_event, .irq_ack,
    .irq_line, .fault_irq, .diag_fail, .link_rx_idle, .rev_mismatch, .power_fail_pin,
    .bp_wdog_fail_pin, .disp, .serial_enable, .baud_tick);
  lmif_host_model host (.core_clk, .dp_req, .dp_rdata, .irq_ack);
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (baud_tick === 1'b1) ticks = ticks + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_word(logic p, logic e, logic a, logic [1:0] s);
    return {p, 7'h00, e, 4'h0, a, s};
  endfunction
  function automatic logic [15:0] exp_code(int i);
    return i == 0 ? 16'h01f0 : i == 5 ? 16'h03f0 : 16'h02f0 + 16'(i - 1);
  endfunction
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    checked = checked + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("BAD %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_disp(input lmif_disp_t g, input lmif_disp_t e);
    checked = checked + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("BAD %0t display %h expected %h", $time, g, e);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic rst();
    nrst = 1'b0;
    {irq_event, link_rx_idle, rev_mismatch, power_fail_pin, bp_wdog_fail_pin} = 5'h00;
    diag_fail = '0;
    fault_irq = '0;
    step(5);
    nrst = 1'b1;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    {seed, fail_count, checked, cyc, ticks} = {32'd37407, 128'h0};
    rst();
    chk_disp(disp, '{1'b0, 5'h1f});
    for (k = 0; k < 8; k++) begin
      got = 16'($random(seed));
      got[1:0] = k[1:0];
      got[7] = k < 4 || got[7];
      {en, al, sel} = {got[7], got[2], got[1:0]};
      host.wr(12'h000, got);
      host.rd(12'h000, got);
      chk_word(got, exp_word(1'b0, en, al, sel));
      step(1);
      irq_event = 1'b1;
      step(1);
      irq_event = 1'b0;
      chk_word({12'h000, irq_line}, en ? 16'h0001 << sel : 16'h0000);
      host.rd(12'h000, got);
      chk_word(got, exp_word(1'b1, en, al, sel));
      host.ack(k % 3);
      chk_word({12'h000, irq_line}, 16'h0000);
    end
    $display("test interrupt word done");
    host.wr(12'h03c, 16'hffff);
    host.wr({2'h1, 10'($random(seed))}, 16'h0000);
    host.rd(12'h000, got);
    chk_word(got, exp_word(1'b0, en, al, sel));
    host.rd(12'h03c, got);
    chk_word(got, 16'h0000);
    host.rd({2'h2, 10'($random(seed))}, got);
    chk_word(got, 16'h0000);
    $display("test refused access done");
    rst();
    link_rx_idle = 1'b1;
    step(2);
    chk_disp(disp, '{1'b0, 5'h0c});
    link_rx_idle = 1'b0;
    step(2);
    chk_disp(disp, '{1'b0, 5'h1f});
    rev_mismatch = 1'b1;
    step(2);
    chk_disp(disp, '{1'b1, 5'h10});
    {power_fail_pin, bp_wdog_fail_pin} = 2'h3;
    step(4);
    chk_disp(disp, '{1'b0, 5'h0e});
    power_fail_pin = 1'b0;
    step(4);
    ticks = 0;
    step(20);
    chk_disp(disp, '{1'b0, 5'h0d});
    chk_word({15'h0000, serial_enable}, 16'h0000);
    chk_word(16'(ticks), 16'h0000);
    bp_wdog_fail_pin = 1'b0;
    step(4);
    ticks = 0;
    step(12);
    chk_word(16'(ticks), 16'h0003);
    $display("test display codes done");
    for (k = 0; k < 9; k++) begin
      rst();
      diag_fail = 9'(($random(seed) | 1) << k);
      step(2);
      {diag_fail, rev_mismatch} = 10'h001;
      step(2);
      chk_disp(disp, '{1'b0, dg[k]});
    end
    $display("test diagnostics done");
    for (k = 0; k < 6; k++) begin
      rst();
      power_fail_pin = k[0];
      fault_irq = lmif_fault_t'(k == 0 ? 6'h20 : k == 5 ? 6'h01 : 6'h01 << k);
      step(1);
      fault_irq = lmif_fault_t'(6'h3f);
      step(1);
      fault_irq = '0;
      host.rd(12'h03c, got);
      chk_word(got, exp_code(k));
      step(6);
      chk_disp(disp, '{1'b1, k == 0 ? 5'h03 : 5'h04});
    end
    $display("test fatal faults done");
    complete_run();
  end
endmodule
`default_nettype wire
